// *** cfm_pkg.sv ***
// Constants for the clock failure monitor and main clock status block.
// Assumes a 32-bit APB slave; register word index times four is the byte address.
package cfm_pkg;
  // Register word indices
  localparam logic [5:0] IDX_MAIN_CTRL = 6'h00;
  localparam logic [5:0] IDX_MON_CTRL = 6'h02;
  localparam logic [5:0] IDX_IRQ_CTRL = 6'h03;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h05;
  localparam logic [5:0] IDX_FOSC_CTRL = 6'h08;
  // Main clock control fields
  localparam int MAIN_PIN_BIT = 7;
  localparam int MAIN_SRC_LSB = 0;
  localparam logic [3:0] MAIN_SRC_LAST = 4'h3;
  // Monitor control fields
  localparam int MON_SRC_LSB = 2;
  localparam int MON_TEST_BIT = 1;
  localparam int MON_EN_BIT = 0;
  localparam logic [1:0] MON_SRC_MAIN = 2'h0;
  localparam logic [1:0] MON_SRC_EXT_FAST = 2'h1;
  localparam logic [1:0] MON_SRC_EXT_SLOW = 2'h2;
  // Interrupt control and flag fields
  localparam int IRQ_KIND_BIT = 7;
  localparam int IRQ_EN_BIT = 0;
  localparam int FLAG_BIT = 0;
  // Status fields
  localparam int ST_PLL_BIT = 5;
  localparam int ST_EXT_FAST_BIT = 4;
  localparam int ST_EXT_SLOW_BIT = 3;
  localparam int ST_INT_SLOW_BIT = 2;
  localparam int ST_INT_FAST_BIT = 1;
  localparam int ST_SWITCH_BIT = 0;
  // Main clock source codes
  localparam logic [3:0] SRC_INT_FAST = 4'h0;
  localparam logic [3:0] SRC_INT_SLOW = 4'h1;
  localparam logic [3:0] SRC_EXT_SLOW = 4'h2;
  localparam logic [3:0] SRC_EXT_FAST = 4'h3;
  // Fast internal oscillator control
  localparam logic [7:0] FOSC_RESET = 8'h0c;
  localparam logic [7:0] FOSC_WMASK = 8'hbd;
  localparam int FOSC_STBY_BIT = 7;
  localparam int FOSC_FRQ_LSB = 2;
  localparam int FOSC_TRIM_BIT = 0;
  // Other reset values
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// *** cfm_clock_monitor.sv ***
// Clock failure monitor, failure interrupt and main clock status registers.
// Assumes APB master on pclk; oscillator status and loss inputs are synchronous to pclk.
// Contract
// - Source field picks watched clock: 0 main, 1 ext fast, 2 ext slow.
// - Enable, irq enable and nmi kind all set locks monitor source, enable and irq control until reset; test bit stays writable.
// - Writing 0 to test bit clears it and the forced failure.
// - Writing 1 to test bit sets it; it forces a failure condition only while the monitor is enabled.
// - Monitor enable bit 0 turns failure detection on or off.
// - Irq kind bit 7 selects regular interrupt (0) or nmi (1).
// - Irq enable bit 0 permits or suppresses the failure interrupt.
// - Failure flag bit 0 sets on any detected failure, forced included.
// - Writing 1 clears the failure flag; writing 0 leaves it.
// - Status bit 5 shows the PLL running, read only.
// - Status bit 4 shows ext fast crystal stable or clock running.
// - Status bit 3 shows ext slow crystal stable or clock running.
// - Status bit 2 shows internal slow oscillator stable.
// - Status bit 1 shows internal fast oscillator stable.
// - Status bit 0 is high while a main source switch waits for stability.
// - Fast osc control resets to 0x0C; bits 7, 5:2, 0 used.
// - Failure on the watched main clock clears the clock pin enable.
//
// Decided for this implementation: the APB interface to the registers.
module cfm_clock_monitor
  import cfm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_clock_lost,
  input wire logic ext_fast_lost,
  input wire logic ext_slow_lost,
  input wire logic pll_running,
  input wire logic fast_ext_kind_select,
  input wire logic ext_fast_crystal_stable,
  input wire logic ext_fast_clock_running,
  input wire logic ext_slow_kind_select,
  input wire logic ext_slow_crystal_stable,
  input wire logic ext_slow_clock_running,
  input wire logic int_slow_osc_stable,
  input wire logic int_fast_osc_stable,
  output logic failure_irq,
  output logic failure_nmi,
  output logic main_clock_pin_output,
  output logic [3:0] main_clock_source,
  output logic run_in_standby,
  output logic [3:0] fast_osc_frequency,
  output logic crystal_trim_enable
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] mon_src;
    logic mon_test;
    logic mon_en;
    logic irq_kind;
    logic irq_en;
    logic flag;
    logic locked;
    logic pin_en;
    logic [3:0] req_src;
    logic [3:0] act_src;
    logic pending;
    logic [7:0] fosc;
    logic irq;
    logic nmi;
  } cfm_state_t;

  cfm_state_t s_reg;
  cfm_state_t s_next;

  logic [5:0] idx;
  logic mapped;
  logic done;
  logic wr;
  logic fail_now;
  logic [7:0] status_now;
  logic [7:0] wbyte;
  logic lock_now;

  // Index table of implemented registers
  function automatic logic is_mapped(input logic [5:0] i);
    return (i == IDX_MAIN_CTRL) || (i == IDX_MON_CTRL) || (i == IDX_IRQ_CTRL)
        || (i == IDX_IRQ_FLAGS) || (i == IDX_STATUS) || (i == IDX_FOSC_CTRL);
  endfunction

  // Stability of a candidate main clock source
  function automatic logic src_ready(input logic [3:0] src, input logic [7:0] st);
    unique case (src)
      SRC_INT_FAST: return st[ST_INT_FAST_BIT];
      SRC_INT_SLOW: return st[ST_INT_SLOW_BIT];
      SRC_EXT_SLOW: return st[ST_EXT_SLOW_BIT];
      SRC_EXT_FAST: return st[ST_EXT_FAST_BIT];
      default: return 1'b0;
    endcase
  endfunction

  assign idx = paddr[7:2];
  assign mapped = is_mapped(idx) && (paddr[1:0] == 2'h0);
  // A request completes only at the edge where pready is seen high
  assign done = psel && penable && s_reg.pready;
  assign wr = done && pwrite && mapped;
  assign wbyte = pwdata[7:0];
  // Lock already holds in the cycle the three bits read one, before the lock flop
  assign lock_now = s_reg.locked || (s_reg.mon_en && s_reg.irq_en && s_reg.irq_kind);

  always_comb
  begin
    status_now = REG_ZERO;
    status_now[ST_PLL_BIT] = pll_running;
    status_now[ST_EXT_FAST_BIT] = fast_ext_kind_select ? ext_fast_clock_running
                                                      : ext_fast_crystal_stable;
    status_now[ST_EXT_SLOW_BIT] = ext_slow_kind_select ? ext_slow_clock_running
                                                      : ext_slow_crystal_stable;
    status_now[ST_INT_SLOW_BIT] = int_slow_osc_stable;
    status_now[ST_INT_FAST_BIT] = int_fast_osc_stable;
    status_now[ST_SWITCH_BIT] = s_reg.pending;
  end

  // Reserved source codes watch nothing; forcing needs the monitor enabled
  always_comb
  begin
    fail_now = 1'b0;
    if (s_reg.mon_en)
    begin
      fail_now = s_reg.mon_test;
      unique case (s_reg.mon_src)
        MON_SRC_MAIN: fail_now = fail_now | main_clock_lost;
        MON_SRC_EXT_FAST: fail_now = fail_now | ext_fast_lost;
        MON_SRC_EXT_SLOW: fail_now = fail_now | ext_slow_lost;
        default: fail_now = fail_now;
      endcase
    end
  end

  always_comb
  begin
    s_next = s_reg;
    // Bus side: one wait state, response held for a single cycle
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = psel && penable && !s_reg.pready && !mapped;
    if (psel && penable && !s_reg.pready)
    begin
      s_next.prdata = RDATA_ZERO;
      if (mapped && !pwrite)
      begin
        unique case (idx)
          IDX_MAIN_CTRL:
          begin
            s_next.prdata[MAIN_PIN_BIT] = s_reg.pin_en;
            s_next.prdata[MAIN_SRC_LSB +: 4] = s_reg.req_src;
          end
          IDX_MON_CTRL:
          begin
            s_next.prdata[MON_SRC_LSB +: 2] = s_reg.mon_src;
            s_next.prdata[MON_TEST_BIT] = s_reg.mon_test;
            s_next.prdata[MON_EN_BIT] = s_reg.mon_en;
          end
          IDX_IRQ_CTRL:
          begin
            s_next.prdata[IRQ_KIND_BIT] = s_reg.irq_kind;
            s_next.prdata[IRQ_EN_BIT] = s_reg.irq_en;
          end
          IDX_IRQ_FLAGS: s_next.prdata[FLAG_BIT] = s_reg.flag;
          IDX_STATUS: s_next.prdata[7:0] = status_now;
          IDX_FOSC_CTRL: s_next.prdata[7:0] = s_reg.fosc;
          default: s_next.prdata = RDATA_ZERO;
        endcase
      end
    end

    if (wr)
    begin
      unique case (idx)
        IDX_MAIN_CTRL:
        begin
          s_next.pin_en = wbyte[MAIN_PIN_BIT];
          // Reserved source codes are dropped rather than stalling a switch
          if (wbyte[MAIN_SRC_LSB +: 4] <= MAIN_SRC_LAST)
            s_next.req_src = wbyte[MAIN_SRC_LSB +: 4];
        end
        IDX_MON_CTRL:
        begin
          s_next.mon_test = wbyte[MON_TEST_BIT];
          if (!lock_now)
          begin
            s_next.mon_src = wbyte[MON_SRC_LSB +: 2];
            s_next.mon_en = wbyte[MON_EN_BIT];
          end
        end
        IDX_IRQ_CTRL:
        begin
          if (!lock_now)
          begin
            s_next.irq_kind = wbyte[IRQ_KIND_BIT];
            s_next.irq_en = wbyte[IRQ_EN_BIT];
          end
        end
        IDX_IRQ_FLAGS:
        begin
          if (wbyte[FLAG_BIT])
            s_next.flag = 1'b0;
        end
        IDX_FOSC_CTRL: s_next.fosc = wbyte & FOSC_WMASK;
        default: s_next.flag = s_next.flag;
      endcase
    end

    // Failure sets flag, beating a same-cycle clear
    if (fail_now)
      s_next.flag = 1'b1;

    if (fail_now && (s_reg.mon_src == MON_SRC_MAIN))
      s_next.pin_en = 1'b0;

    if (lock_now)
      s_next.locked = 1'b1;

    // Change over when the target is stable
    s_next.pending = (s_next.req_src != s_reg.act_src);
    if (s_reg.pending && src_ready(s_reg.req_src, status_now))
    begin
      s_next.act_src = s_reg.req_src;
      s_next.pending = (s_next.req_src != s_reg.req_src);
    end

    s_next.irq = s_next.flag && s_next.irq_en && !s_next.irq_kind;
    s_next.nmi = s_next.flag && s_next.irq_en && s_next.irq_kind;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.fosc <= FOSC_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign failure_irq = s_reg.irq;
  assign failure_nmi = s_reg.nmi;
  assign main_clock_pin_output = s_reg.pin_en;
  assign main_clock_source = s_reg.act_src;
  assign run_in_standby = s_reg.fosc[FOSC_STBY_BIT];
  assign fast_osc_frequency = s_reg.fosc[FOSC_FRQ_LSB +: 4];
  assign crystal_trim_enable = s_reg.fosc[FOSC_TRIM_BIT];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  lock_holds_config_a: assert property (
    s_reg.locked |=> $stable({s_reg.mon_src, s_reg.mon_en, s_reg.irq_en, s_reg.irq_kind})
                     && s_reg.locked)
    else $error("Locked monitor configuration changed");

  lock_sets_a: assert property (
    s_reg.mon_en && s_reg.irq_en && s_reg.irq_kind |=> s_reg.locked)
    else $error("Lock did not engage");

  flag_on_fail_a: assert property (
    fail_now |=> s_reg.flag)
    else $error("Failure did not set the flag");

  flag_w1c_a: assert property (
    wr && idx == IDX_IRQ_FLAGS && !fail_now
      |=> (s_reg.flag == ($past(s_reg.flag) && !$past(wbyte[FLAG_BIT]))))
    else $error("Flag write one to clear misbehaved");

  test_forces_fail_a: assert property (
    wr && idx == IDX_MON_CTRL && wbyte[MON_TEST_BIT] && (wbyte[MON_EN_BIT] || lock_now)
      |=> ##1 s_reg.flag)
    else $error("Test write did not force a failure");

  test_clear_a: assert property (
    wr && idx == IDX_MON_CTRL && !wbyte[MON_TEST_BIT] |=> !s_reg.mon_test)
    else $error("Test bit not cleared");

  pin_drop_a: assert property (
    fail_now && s_reg.mon_src == MON_SRC_MAIN |=> !main_clock_pin_output)
    else $error("Clock pin stayed enabled after main clock failure");

  irq_route_a: assert property (
    s_reg.flag && s_reg.irq_en
      |-> (failure_irq != s_reg.irq_kind) && (failure_nmi == s_reg.irq_kind))
    else $error("Failure interrupt routed wrongly");

  irq_off_a: assert property (
    !s_reg.irq_en |-> !failure_irq && !failure_nmi)
    else $error("Interrupt raised while disabled");

  status_read_a: assert property (
    pready && !$past(pready) && !pslverr && !$past(pwrite) && $past(idx) == IDX_STATUS
      |-> prdata[ST_PLL_BIT] == $past(pll_running)
          && prdata[ST_INT_FAST_BIT] == $past(int_fast_osc_stable))
    else $error("Status read did not reflect oscillator inputs");

  switch_done_a: assert property (
    s_reg.pending && src_ready(s_reg.req_src, status_now) && !wr
      |=> main_clock_source == $past(s_reg.req_src) && !s_reg.pending)
    else $error("Main clock switch did not complete");

  fosc_unused_a: assert property (
    s_reg.fosc[6] == 1'b0 && s_reg.fosc[1] == 1'b0)
    else $error("Unused fast oscillator bits set");

  pready_pulse_a: assert property (
    pready |=> !pready)
    else $error("Ready held longer than one cycle");

  lock_seen_c: cover property (s_reg.locked && wr && idx == IDX_MON_CTRL);
  forced_fail_c: cover property (s_reg.mon_test && s_reg.mon_en ##1 s_reg.flag);
  nmi_seen_c: cover property (failure_nmi);
  switch_seen_c: cover property (s_reg.pending ##[1:20] !s_reg.pending);

endmodule

// *** cfm_osc_model.sv ***
// Model of the oscillators, crystals and PLL that feed the monitor.
// Assumes the bench sets wanted levels on ctl; with slow set they settle every fourth cycle.
module cfm_osc_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [11:0] ctl,
  output logic [11:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tick_reg;
  // Lines lag the request, as a real source never answers at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_reg <= 2'h0;
      lines <= 12'h000;
    end
    else
    begin
      tick_reg <= tick_reg + 2'h1;
      if (!slow || tick_reg == 2'h3)
      begin
        lines <= ctl;
      end
    end
  end
endmodule

// *** clock_failure_monitor_status_tb.sv ***
// Self-checking bench for the clock failure monitor and status block.
// Assumes the APB slave answers with pready in bounded time and the oscillator model.
module clock_failure_monitor_status_tb
  import cfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, last_err;
  logic irq, nmi, pin, stby, trim;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] src, frq;
  logic [11:0] ctl, lines, k;
  int mismatches, comparisons, cycles;

  cfm_osc_model osc (.pclk(pclk), .presetn(presetn), .slow(slow), .ctl(ctl), .lines(lines));
  cfm_clock_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_clock_lost(lines[0]), .ext_fast_lost(lines[1]),
    .ext_slow_lost(lines[2]), .pll_running(lines[3]), .fast_ext_kind_select(lines[4]),
    .ext_fast_crystal_stable(lines[5]), .ext_fast_clock_running(lines[6]),
    .ext_slow_kind_select(lines[7]), .ext_slow_crystal_stable(lines[8]),
    .ext_slow_clock_running(lines[9]), .int_slow_osc_stable(lines[10]),
    .int_fast_osc_stable(lines[11]), .failure_irq(irq), .failure_nmi(nmi),
    .main_clock_pin_output(pin), .main_clock_source(src), .run_in_standby(stby),
    .fast_osc_frequency(frq), .crystal_trim_enable(trim));

  always #50 pclk = ~pclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Status model built from the source levels with plain integers
  function automatic logic [31:0] stat_exp(input logic [11:0] v);
    int r;
    r = v[3] * 32 + (v[4] ? v[6] : v[5]) * 16 + (v[7] ? v[9] : v[8]) * 8;
    r = r + v[10] * 4 + v[11] * 2;
    return 32'(r);
  endfunction

  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    slow = 0;
    ctl = 0;
    seed = 32'h0000_61f9;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h0c, 8'h00);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h20, 8'h0c);
    rd_chk(8'h18, 8'h00);
    chk(32'(last_err), 32'h0000_0001);
    $display("test reset done");
    slow <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      k = {seed[11:3], 3'h0};
      ctl <= k;
      repeat (10) @(posedge pclk);
      rd_chk(8'h14, 8'(stat_exp(k)));
    end
    slow <= 1'b0;
    ctl <= 12'h800;
    wr(8'h20, 8'hff);
    rd_chk(8'h20, 8'hbd);
    chk(32'({stby, frq, trim}), 32'h0000_003f);
    $display("test status done");
    wr(8'h00, 8'h80);
    chk(32'(pin), 32'h0000_0001);
    wr(8'h08, 8'h01);
    ctl <= 12'h801;
    repeat (4) @(posedge pclk);
    chk(32'(pin), 32'h0000_0000);
    rd_chk(8'h00, 8'h00);
    wr(8'h08, 8'h02);
    ctl <= 12'h807;
    wr(8'h10, 8'h01);
    repeat (4) @(posedge pclk);
    rd_chk(8'h10, 8'h00);
    ctl <= 12'h800;
    wr(8'h08, 8'h03);
    rd_chk(8'h10, 8'h01);
    rd_chk(8'h08, 8'h03);
    wr(8'h08, 8'h01);
    wr(8'h10, 8'h01);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h08, 8'h01);
    $display("test force done");
    for (int s = 0; s < 3; s++)
    begin
      wr(8'h0c, 8'h01);
      wr(8'h08, 8'((s << 2) | 1));
      ctl <= 12'h800 | (12'h001 << ((s + 1) % 3));
      repeat (4) @(posedge pclk);
      rd_chk(8'h10, 8'h00);
      ctl <= 12'h800 | (12'h001 << s);
      repeat (4) @(posedge pclk);
      ctl <= 12'h800;
      rd_chk(8'h10, 8'h01);
      chk(32'({irq, nmi}), 32'h0000_0002);
      wr(8'h0c, 8'h00);
      chk(32'(irq), 32'h0000_0000);
      wr(8'h10, 8'h00);
      rd_chk(8'h10, 8'h01);
      wr(8'h10, 8'h01);
      rd_chk(8'h10, 8'h00);
    end
    $display("test sources done");
    wr(8'h00, 8'h01);
    rd_chk(8'h14, 8'h03);
    ctl <= 12'hc00;
    repeat (4) @(posedge pclk);
    chk(32'(src), 32'h0000_0001);
    rd_chk(8'h14, 8'h06);
    $display("test switch done");
    wr(8'h08, 8'h01);
    wr(8'h0c, 8'h81);
    wr(8'h08, 8'h03);
    // Flag and request rise on the edge that ends the write; look one edge later
    @(posedge pclk);
    chk(32'({irq, nmi}), 32'h0000_0001);
    wr(8'h08, 8'h0a);
    rd_chk(8'h08, 8'h03);
    wr(8'h0c, 8'h00);
    rd_chk(8'h0c, 8'h81);
    // Only a reset releases the lock
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({irq, nmi}), 32'h0000_0000);
    rd_chk(8'h10, 8'h00);
    wr(8'h08, 8'h05);
    rd_chk(8'h08, 8'h05);
    $display("test lock done");
    give_verdict();
  end
endmodule
